// [common/led_blink_map.vh]
// Register addresses, field positions and reset values of the blink phase register bank.
`ifndef LED_BLINK_MAP_VH
`define LED_BLINK_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_PHASE0_LOW   8'h02
`define ADDR_PHASE0_HIGH  8'h03
`define ADDR_PHASE1_LOW   8'h0A
`define ADDR_PHASE1_HIGH  8'h0B
`define ADDR_MASTER       8'h0E
`define ADDR_CONFIG       8'h0F
`define ADDR_INTENS_0     8'h10
`define ADDR_INTENS_1     8'h11
`define ADDR_INTENS_2     8'h12
`define ADDR_INTENS_3     8'h13
`define ADDR_INTENS_4     8'h14
`define ADDR_INTENS_5     8'h15
`define ADDR_INTENS_6     8'h16
`define ADDR_INTENS_7     8'h17

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define CFG_BLINK_EN      0
`define CFG_BLINK_FLIP    1
`define CFG_GLOBAL        2
`define CFG_LAST_P0       4
`define CFG_LAST_P1       5
`define CFG_PIN_STATUS    6
`define CFG_WRITE_MASK    8'h37

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define REG_RESET         8'h00
`define NIB_RESET         4'h0
`define BYTE_ZERO         8'h00
`define NUM_OUTPUTS       17
`define NUM_INTENS_REGS   8
`define NUM_LEVEL_OUTPUTS 16
`define PORT_SINK_LEVEL   17'h00000

`endif

// [logic/byte_store.v]
// One eight-bit read/write storage register.
`include "led_blink_map.vh"

module byte_store (
	input  wire       clk,
	input  wire       rst,
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	output reg  [7:0] q
);

	always @(posedge clk) begin
		if (rst) begin
			q <= `REG_RESET;
		end else if (wr_en) begin
			q <= wr_data;
		end
	end

endmodule

// [logic/od_output_cell.v]
// Level and intensity selection for one open-drain output.
`include "led_blink_map.vh"

module od_output_cell (
	input  wire       clk,
	input  wire       rst,
	input  wire       level_p0,
	input  wire       level_p1,
	input  wire       phase1_sel,
	input  wire [3:0] own_nib,
	input  wire [3:0] glob_nib,
	input  wire       glob_flag,
	output reg        drive_low,
	output reg  [3:0] intensity
);

	wire level;

	assign level = phase1_sel ? level_p1 : level_p0;

	always @(posedge clk) begin
		if (rst) begin
			drive_low <= 1'b0;
			intensity <= `NIB_RESET;
		end else begin
			drive_low <= ~level;
			intensity <= glob_flag ? glob_nib : own_nib;
		end
	end

endmodule

// [logic/led_blink_phase_config.v]
// Configuration and blink phase register bank of a seventeen-output open-drain expander.
//
// What this block does
// - Configuration register at 0x0F: enable, flip, global, last-output phase bits, pin status.
// - Configuration bits D7 and D3 ignore writes and read back as zero.
// - Global flag clear: outputs use own nibble 0x10-0x17; last output uses 0x0E.
// - Global flag set: every output uses low nibble of 0x0E.
// - Blink off: last output low when D4 is 0, released when 1.
// - Blink on: last output follows D4 in phase 0, D5 in phase 1.
// - Reading D6 returns the phase input pin level; writes to it do nothing.
// - Blink on: phase-1 registers chosen when flip XOR pin is 1, else phase 0.
// - Blink off: only phase-0 registers set the levels, whatever flip and pin are.
// - Phase-0 levels of outputs 0-7 at 0x02, 8-15 at 0x03, bit n mod 8.
// - Phase-1 levels of outputs 0-7 at 0x0A, 8-15 at 0x0B, same order.
// - Every phase register reads back the last value written.
`include "led_blink_map.vh"

module led_blink_phase_config (
	input  wire        clk,
	input  wire        rst,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr_en,
	input  wire [7:0]  reg_wr_data,
	input  wire        reg_rd_en,
	input  wire        blink_pin,
	output reg  [7:0]  rd_data_reg,
	output reg         rd_valid_reg,
	output reg         phase1_active_reg,
	output reg  [16:0] port_out_reg,
	output wire [16:0] port_oe,
	output wire [67:0] port_intensity
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	reg  [7:0] config_reg;
	wire [7:0] config_next;
	wire [7:0] phase0_low;
	wire [7:0] phase0_high;
	wire [7:0] phase1_low;
	wire [7:0] phase1_high;
	wire [7:0] master_reg;
	wire [63:0] intens_flat;
	wire [7:0]  intens_0;
	wire [7:0]  intens_1;
	wire [7:0]  intens_2;
	wire [7:0]  intens_3;
	wire [7:0]  intens_4;
	wire [7:0]  intens_5;
	wire [7:0]  intens_6;
	wire [7:0]  intens_7;
	wire        wr_intens_0;
	wire        wr_intens_1;
	wire        wr_intens_2;
	wire        wr_intens_3;
	wire        wr_intens_4;
	wire        wr_intens_5;
	wire        wr_intens_6;
	wire        wr_intens_7;
	wire        phase1_sel;
	wire [15:0] level_p0;
	wire [15:0] level_p1;
	reg  [7:0]  rd_data_next;

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Masking at the write keeps the fixed-zero and pin status bits out of storage.
	assign config_next = reg_wr_data & `CFG_WRITE_MASK;

	always @(posedge clk) begin
		if (rst) begin
			config_reg <= `REG_RESET;
		end else if (reg_wr_en && reg_addr == `ADDR_CONFIG) begin
			config_reg <= config_next;
		end
	end

	// ----------------------------------------
	// Phase level and master registers
	// ----------------------------------------
	byte_store u_phase0_low (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr_en && reg_addr == `ADDR_PHASE0_LOW),
		.wr_data (reg_wr_data),
		.q       (phase0_low)
	);

	byte_store u_phase0_high (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr_en && reg_addr == `ADDR_PHASE0_HIGH),
		.wr_data (reg_wr_data),
		.q       (phase0_high)
	);

	byte_store u_phase1_low (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr_en && reg_addr == `ADDR_PHASE1_LOW),
		.wr_data (reg_wr_data),
		.q       (phase1_low)
	);

	byte_store u_phase1_high (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr_en && reg_addr == `ADDR_PHASE1_HIGH),
		.wr_data (reg_wr_data),
		.q       (phase1_high)
	);

	byte_store u_master (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr_en && reg_addr == `ADDR_MASTER),
		.wr_data (reg_wr_data),
		.q       (master_reg)
	);

	// ----------------------------------------
	// Individual intensity registers
	// ----------------------------------------
	assign wr_intens_0 = reg_wr_en && (reg_addr == `ADDR_INTENS_0);
	assign wr_intens_1 = reg_wr_en && (reg_addr == `ADDR_INTENS_1);
	assign wr_intens_2 = reg_wr_en && (reg_addr == `ADDR_INTENS_2);
	assign wr_intens_3 = reg_wr_en && (reg_addr == `ADDR_INTENS_3);
	assign wr_intens_4 = reg_wr_en && (reg_addr == `ADDR_INTENS_4);
	assign wr_intens_5 = reg_wr_en && (reg_addr == `ADDR_INTENS_5);
	assign wr_intens_6 = reg_wr_en && (reg_addr == `ADDR_INTENS_6);
	assign wr_intens_7 = reg_wr_en && (reg_addr == `ADDR_INTENS_7);

	byte_store u_intens_0 (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_intens_0),
		.wr_data (reg_wr_data),
		.q       (intens_0)
	);

	byte_store u_intens_1 (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_intens_1),
		.wr_data (reg_wr_data),
		.q       (intens_1)
	);

	byte_store u_intens_2 (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_intens_2),
		.wr_data (reg_wr_data),
		.q       (intens_2)
	);

	byte_store u_intens_3 (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_intens_3),
		.wr_data (reg_wr_data),
		.q       (intens_3)
	);

	byte_store u_intens_4 (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_intens_4),
		.wr_data (reg_wr_data),
		.q       (intens_4)
	);

	byte_store u_intens_5 (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_intens_5),
		.wr_data (reg_wr_data),
		.q       (intens_5)
	);

	byte_store u_intens_6 (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_intens_6),
		.wr_data (reg_wr_data),
		.q       (intens_6)
	);

	byte_store u_intens_7 (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_intens_7),
		.wr_data (reg_wr_data),
		.q       (intens_7)
	);

	// The low nibble of each intensity register serves the even output of its pair.
	assign intens_flat = {intens_7, intens_6, intens_5, intens_4,
		intens_3, intens_2, intens_1, intens_0};

	genvar gi;

	// ----------------------------------------
	// Register read back
	// ----------------------------------------
	// The pin is sampled at the read, so status reflects the level one cycle before
	// the data appears; no synchroniser is needed as the pin is synchronous here.
	always @* begin
		rd_data_next = `BYTE_ZERO;
		case (1'b1)
			reg_addr == `ADDR_PHASE0_LOW:  rd_data_next = phase0_low;
			reg_addr == `ADDR_PHASE0_HIGH: rd_data_next = phase0_high;
			reg_addr == `ADDR_PHASE1_LOW:  rd_data_next = phase1_low;
			reg_addr == `ADDR_PHASE1_HIGH: rd_data_next = phase1_high;
			reg_addr == `ADDR_MASTER:      rd_data_next = master_reg;
			reg_addr == `ADDR_CONFIG: begin
				rd_data_next = config_reg;
				rd_data_next[`CFG_PIN_STATUS] = blink_pin;
			end
			reg_addr == `ADDR_INTENS_0:    rd_data_next = intens_0;
			reg_addr == `ADDR_INTENS_1:    rd_data_next = intens_1;
			reg_addr == `ADDR_INTENS_2:    rd_data_next = intens_2;
			reg_addr == `ADDR_INTENS_3:    rd_data_next = intens_3;
			reg_addr == `ADDR_INTENS_4:    rd_data_next = intens_4;
			reg_addr == `ADDR_INTENS_5:    rd_data_next = intens_5;
			reg_addr == `ADDR_INTENS_6:    rd_data_next = intens_6;
			reg_addr == `ADDR_INTENS_7:    rd_data_next = intens_7;
			default:                       rd_data_next = `BYTE_ZERO;
		endcase
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	// Data is captured only on a read, so it stands until the next read.
	always @(posedge clk) begin
		if (rst) begin
			rd_data_reg  <= `BYTE_ZERO;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= reg_rd_en;
			if (reg_rd_en) begin
				rd_data_reg <= rd_data_next;
			end
		end
	end

	// ----------------------------------------
	// Phase selection and output stage
	// ----------------------------------------
	assign phase1_sel = config_reg[`CFG_BLINK_EN] &
		(config_reg[`CFG_BLINK_FLIP] ^ blink_pin);

	assign level_p0 = {phase0_high, phase0_low};
	assign level_p1 = {phase1_high, phase1_low};

	// Open-drain pins can only sink, so the output data never leaves the low level.
	always @(posedge clk) begin
		if (rst) begin
			phase1_active_reg <= 1'b0;
			port_out_reg      <= `PORT_SINK_LEVEL;
		end else begin
			phase1_active_reg <= phase1_sel;
			port_out_reg      <= `PORT_SINK_LEVEL;
		end
	end

	// ----------------------------------------
	// Open-drain output cells
	// ----------------------------------------
	generate
		for (gi = 0; gi < `NUM_LEVEL_OUTPUTS; gi = gi + 1) begin : g_out
			od_output_cell u_cell (
				.clk        (clk),
				.rst        (rst),
				.level_p0   (level_p0[gi]),
				.level_p1   (level_p1[gi]),
				.phase1_sel (phase1_sel),
				.own_nib    (intens_flat[gi*4 +: 4]),
				.glob_nib   (master_reg[3:0]),
				.glob_flag  (config_reg[`CFG_GLOBAL]),
				.drive_low  (port_oe[gi]),
				.intensity  (port_intensity[gi*4 +: 4])
			);
		end
	endgenerate

	// The last output keeps both of its level bits in the configuration register.
	od_output_cell u_last (
		.clk        (clk),
		.rst        (rst),
		.level_p0   (config_reg[`CFG_LAST_P0]),
		.level_p1   (config_reg[`CFG_LAST_P1]),
		.phase1_sel (phase1_sel),
		.own_nib    (master_reg[3:0]),
		.glob_nib   (master_reg[3:0]),
		.glob_flag  (config_reg[`CFG_GLOBAL]),
		.drive_low  (port_oe[16]),
		.intensity  (port_intensity[67:64])
	);

endmodule

// [test/blink_bank_sva.sv]
// Port checker for the blink phase register bank.
module blink_bank_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr_en,
	input wire logic [7:0]  reg_wr_data,
	input wire logic        reg_rd_en,
	input wire logic        blink_pin,
	input wire logic [7:0]  rd_data_reg,
	input wire logic        rd_valid_reg,
	input wire logic        phase1_active_reg,
	input wire logic [16:0] port_out_reg,
	input wire logic [16:0] port_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cfg;
	wire sel = cfg[0] & (cfg[1] ^ blink_pin);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Shadow of the writable configuration bits, so reads and outputs can be predicted.
	always @(posedge clk)
		cfg <= rst ? 8'h00 : (reg_wr_en && reg_addr == 8'h0F) ? reg_wr_data & 8'h37 : cfg;
	chk_read_valid: assert property (reg_rd_en |=> rd_valid_reg) else $error("no valid");
	chk_valid_pulse: assert property (!reg_rd_en |=> !rd_valid_reg) else $error("extra valid");
	chk_cfg_read: assert property (reg_rd_en && reg_addr == 8'h0F |=>
		rd_data_reg == $past({1'b0, blink_pin, cfg[5:4], 1'b0, cfg[2:0]}))
		else $error("cfg read");
	chk_phase_sel: assert property (1 |=> phase1_active_reg == $past(sel))
		else $error("phase");
	chk_blink_off: assert property (!cfg[0] |=> !phase1_active_reg) else $error("off");
	chk_last_out: assert property (1 |=> port_oe[16] == !$past(sel ? cfg[5] : cfg[4]))
		else $error("last out");
	chk_sink_only: assert property (port_out_reg == 17'h00000) else $error("high");
	chk_unmapped_zero: assert property (reg_rd_en && reg_addr == 8'h40 |=> rd_data_reg == 8'h00)
		else $error("unmapped");
	cover property (sel);
	cover property (reg_rd_en && reg_addr == 8'h0F);
	cover property (!port_oe[16]);
endmodule
bind led_blink_phase_config blink_bank_sva chk (.clk, .rst, .reg_addr, .reg_wr_en, .reg_wr_data,
	.reg_rd_en, .blink_pin, .rd_data_reg, .rd_valid_reg, .phase1_active_reg, .port_out_reg,
	.port_oe);

// [test/host_model.sv]
// Bus master model driving the register strobes.
module host_model (
	input  wire logic       clk,
	input  wire logic [7:0] rd_data_reg,
	input  wire logic       rd_valid_reg,
	output var  logic [7:0] reg_addr = 8'h00,
	output var  logic       reg_wr_en = 1'b0,
	output var  logic [7:0] reg_wr_data = 8'h00,
	output var  logic       reg_rd_en = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released address and data lines carry the inverse so that a stale value cannot pass.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		#1;
		{reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = {a, d, w, !w};
		@(posedge clk);
		#1;
		{reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = {~a, ~d, 2'b00};
		q = rd_valid_reg ? rd_data_reg : 8'hXX;
	endtask
endmodule

// [test/tb_led_blink_phase_config.sv]
// Self-checking bench for the blink phase register bank.
module tb_led_blink_phase_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        blink_pin = 1'b0;
	logic [7:0]  reg_addr, reg_wr_data, rd_data_reg, q;
	logic        reg_wr_en, reg_rd_en, rd_valid_reg, phase1_active_reg, s;
	logic [16:0] port_out_reg, port_oe;
	logic [67:0] port_intensity;
	int          errors = 0;
	int          total_checks = 0;
	logic [7:0]  pv [4] = '{8'h5A, 8'hC3, 8'h96, 8'h0F};
	always #12.5 clk = ~clk;
	led_blink_phase_config uut (.clk, .rst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
		.blink_pin, .rd_data_reg, .rd_valid_reg, .phase1_active_reg, .port_out_reg, .port_oe,
		.port_intensity);
	host_model hm (.clk, .rd_data_reg, .rd_valid_reg, .reg_addr, .reg_wr_en, .reg_wr_data,
		.reg_rd_en);
	task automatic cmp(input string n, input logic [16:0] v, input logic [16:0] e);
		total_checks++;
		if (v !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
		hm.acc(1'b0, a, 8'h00, q);
		cmp(n, 17'(q), 17'(e));
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		rdc(8'h0F, 8'h00, "cfg reset");
		for (int i = 0; i < 4; i++)
			hm.acc(1'b1, 8'h02 + {4'h0, i[1], 2'b00, i[0]}, pv[i], q);
		for (int i = 0; i < 4; i++)
			rdc(8'h02 + {4'h0, i[1], 2'b00, i[0]}, pv[i], "phase reg");
		hm.acc(1'b1, 8'h40, 8'hFF, q);
		rdc(8'h40, 8'h00, "unmapped");
		rdc(8'h02, 8'h5A, "kept");
		for (int i = 0; i < 4; i++) begin
			s = i[0] ^ i[1];
			hm.acc(1'b1, 8'h0F, 8'hD9 | {6'h00, i[1], 1'b0}, q);
			@(posedge clk);
			#1;
			blink_pin = i[0];
			settle();
			cmp("phase1", 17'(phase1_active_reg), 17'(s));
			cmp("oe blink", port_oe, {s, s ? 16'hF069 : 16'h3CA5});
			rdc(8'h0F, {1'b0, i[0], 6'h10} | {6'h00, i[1], 1'b1}, "cfg");
		end
		hm.acc(1'b1, 8'h0E, 8'h05, q);
		hm.acc(1'b1, 8'h10, 8'h9A, q);
		hm.acc(1'b1, 8'h0F, 8'h08, q);
		settle();
		cmp("phase1 off", 17'(phase1_active_reg), 17'h00000);
		cmp("oe off", port_oe, 17'h13CA5);
		cmp("nibbles", {5'h00, port_intensity[67:64], port_intensity[7:0]}, 17'h0059A);
		hm.acc(1'b1, 8'h0F, 8'h04, q);
		settle();
		cmp("global", {5'h00, port_intensity[67:64], port_intensity[7:0]}, 17'h00555);
		for (int k = 0; k < 8; k++)
			hm.acc(1'b1, 8'h10 + 8'(k), 8'(8'h10 + 8'h22 * k), q);
		settle();
		for (int j = 0; j < 4; j++)
			cmp("global all", 17'(port_intensity[j*16 +: 16]), 17'h05555);
		hm.acc(1'b1, 8'h0F, 8'h00, q);
		settle();
		for (int j = 0; j < 4; j++)
			cmp("own nib", 17'(port_intensity[j*16 +: 16]), 17'(16'h3210 + 16'h4444 * j));
		cmp("last own", 17'(port_intensity[67:64]), 17'h00005);
		for (int k = 0; k < 8; k++)
			rdc(8'h10 + 8'(k), 8'(8'h10 + 8'h22 * k), "intens reg");
		complete_run();
	end
endmodule
